// ---- hw/ets_cfg.svh ----
// offsets, field positions, reset values and timing counts of the timestamp unit
`ifndef ETS_CFG_SVH
`define ETS_CFG_SVH
`define ETS_NUM_CH        2
`define ETS_TIME_W        64
`define ETS_CLK_PERIOD_NS 10
`define ETS_NS_PER_LSB    1
`define ETS_NS_STEP       (`ETS_CLK_PERIOD_NS / `ETS_NS_PER_LSB)
`define ETS_DIR_BIT       3
`define ETS_OFS_CTRL      32'h00
`define ETS_OFS_LEVEL     32'h04
`define ETS_OFS_STAT      32'h08
`define ETS_OFS_MASK      32'h0c
`define ETS_OFS_DIR1      32'h10
`define ETS_OFS_DIR2      32'h14
`define ETS_OFS_TIME      32'h20
`define ETS_OFS_RISE1_LO  32'h40
`define ETS_CTRL_RST      2'h3
`define ETS_MASK_RST      4'h0
`define ETS_READY_RST     1'b1
`endif

// ---- hw/ets_pkg.sv ----
// types of the timestamp unit
package ets_pkg;
    typedef struct packed {
        logic        sel;
        logic        write;
        logic [7:0]  addr;
    } ets_ahb_req_t;
    typedef struct packed {
        logic [1:0]  sync;
        logic        level;
        logic        dir;
        logic [63:0] rise_time;
        logic [63:0] fall_time;
    } ets_ch_t;
endpackage : ets_pkg

// ---- hw/ets_channel.sv ----
// one timestamp input channel: synchroniser, edge detector, two latches
`timescale 1ns/100ps
`include "ets_cfg.svh"
module ets_channel #(
    parameter int TIME_W = `ETS_TIME_W
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              enable,
    input  wire logic              pin_in,
    input  wire logic [TIME_W-1:0] now,
    output ets_pkg::ets_ch_t       ch,
    output logic                   rise_pulse,
    output logic                   fall_pulse
);
    import ets_pkg::*;
    ets_ch_t     r;
    ets_ch_t     next_r;
    logic        next_rise;
    logic        next_fall;

    always_comb begin
        next_r       = r;
        next_rise    = 1'b0;
        next_fall    = 1'b0;
        next_r.sync  = {r.sync[0], pin_in};
        next_r.level = r.sync[1];
        if (enable && r.sync[1] && !r.level) begin
            next_r.rise_time = 64'(now);
            next_r.dir       = 1'b1;
            next_rise        = 1'b1;
        end
        if (enable && !r.sync[1] && r.level) begin
            next_r.fall_time = 64'(now);
            next_r.dir       = 1'b0;
            next_fall        = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r          <= '0;
            rise_pulse <= 1'b0;
            fall_pulse <= 1'b0;
        end else begin
            r          <= next_r;
            rise_pulse <= next_rise;
            fall_pulse <= next_fall;
        end
    end

    assign ch = r;

    property p_rise_stamp;
        @(posedge hclk) disable iff (!hresetn)
        (enable && r.sync[1] && !r.level) |=> (r.rise_time == 64'($past(now)) && r.dir);
    endproperty
    a_rise_stamp: assert property (p_rise_stamp) else $error("rise time not stamped");

    property p_fall_stamp;
        @(posedge hclk) disable iff (!hresetn)
        (enable && !r.sync[1] && r.level) |=> (r.fall_time == 64'($past(now)) && !r.dir);
    endproperty
    a_fall_stamp: assert property (p_fall_stamp) else $error("fall time not stamped");

    property p_rise_hold;
        @(posedge hclk) disable iff (!hresetn)
        hresetn && !rise_pulse |-> $stable(r.rise_time) or $past(!hresetn);
    endproperty
    a_rise_hold: assert property (p_rise_hold)
        else $error("rise time changed without edge");

    property p_fall_hold;
        @(posedge hclk) disable iff (!hresetn)
        hresetn && !fall_pulse |-> $stable(r.fall_time);
    endproperty
    a_fall_hold: assert property (p_fall_hold)
        else $error("fall time changed without edge");

    property p_level_follows;
        @(posedge hclk) disable iff (!hresetn)
        $rose(pin_in) ##1 pin_in ##1 pin_in |=> r.level;
    endproperty
    a_level_follows: assert property (p_level_follows)
        else $error("level not mirrored");

    sequence s_rise_seen;
        rise_pulse;
    endsequence
    property p_pulse_dir;
        @(posedge hclk) disable iff (!hresetn)
        s_rise_seen |-> r.dir && !fall_pulse;
    endproperty
    a_pulse_dir: assert property (p_pulse_dir) else $error("direction flag wrong");
endmodule : ets_channel

// ---- hw/ets_top.sv ----
// timestamp unit top: ns time base, two channels, AHB-Lite registers, interrupt
//
// Chosen here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "ets_cfg.svh"
module ets_top #(
    parameter int NUM_CH = `ETS_NUM_CH,
    parameter int TIME_W = `ETS_TIME_W
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic [31:0]            hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic              first_input_socket,
    input  wire logic              second_input_socket,
    output logic                   irq
);
    import ets_pkg::*;

    typedef struct packed {
        logic [TIME_W-1:0] now;
        ets_ahb_req_t      req;
        logic [1:0]        ctrl;
        logic [3:0]        stat;
        logic [3:0]        mask;
        logic [31:0]       rdata;
        logic              irq;
        logic              ready;
        logic              resp;
    } ets_state_t;

    ets_state_t        s;
    ets_state_t        next_s;
    ets_ch_t           chs    [NUM_CH];
    logic [NUM_CH-1:0] rise_p;
    logic [NUM_CH-1:0] fall_p;
    logic [NUM_CH-1:0] pins;

    assign pins = NUM_CH'({second_input_socket, first_input_socket});

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            ets_channel #(.TIME_W(TIME_W)) u_ch (
                .hclk       (hclk),
                .hresetn    (hresetn),
                .enable     (s.ctrl[g]),
                .pin_in     (pins[g]),
                .now        (s.now),
                .ch         (chs[g]),
                .rise_pulse (rise_p[g]),
                .fall_pulse (fall_p[g])
            );
        end
    endgenerate

    // register read decode, matched on the low address byte haddr[7:0] only; unaligned addresses read zero
    function automatic logic [31:0] read_word(input logic [7:0] a, input ets_state_t st,
                                               input ets_ch_t c0, input ets_ch_t c1);
        logic [31:0] w;
        w = 32'h0;
        unique case (a)
            8'(`ETS_OFS_CTRL):  w = {30'h0, st.ctrl};
            8'(`ETS_OFS_LEVEL): w = {30'h0, c1.level, c0.level};
            8'(`ETS_OFS_STAT):  w = {28'h0, st.stat};
            8'(`ETS_OFS_MASK):  w = {28'h0, st.mask};
            8'(`ETS_OFS_DIR1):  w = 32'(c0.dir) << `ETS_DIR_BIT;
            8'(`ETS_OFS_DIR2):  w = 32'(c1.dir) << `ETS_DIR_BIT;
            8'(`ETS_OFS_TIME):  w = st.now[31:0];
            8'(`ETS_OFS_TIME + 32'h4):     w = st.now[63:32];
            8'(`ETS_OFS_RISE1_LO):         w = c0.rise_time[31:0];
            8'(`ETS_OFS_RISE1_LO + 32'h4): w = c0.rise_time[63:32];
            8'(`ETS_OFS_RISE1_LO + 32'h8): w = c0.fall_time[31:0];
            8'(`ETS_OFS_RISE1_LO + 32'hc): w = c0.fall_time[63:32];
            8'(`ETS_OFS_RISE1_LO + 32'h10): w = c1.rise_time[31:0];
            8'(`ETS_OFS_RISE1_LO + 32'h14): w = c1.rise_time[63:32];
            8'(`ETS_OFS_RISE1_LO + 32'h18): w = c1.fall_time[31:0];
            8'(`ETS_OFS_RISE1_LO + 32'h1c): w = c1.fall_time[63:32];
            default:            w = 32'h0;
        endcase
        return w;
    endfunction : read_word

    // address phase accepted by this slave
    function automatic logic addr_taken(input logic sel, input logic [1:0] trans,
                                        input logic rdy);
        return sel && trans[1] && rdy;
    endfunction : addr_taken

    // data phase of a write to one word
    function automatic logic wr_hit(input ets_ahb_req_t q, input logic [7:0] ofs);
        return q.sel && q.write && (q.addr == ofs);
    endfunction : wr_hit

    logic [3:0] events;
    assign events = {fall_p[1], rise_p[1], fall_p[0], rise_p[0]};

    always_comb begin
        next_s          = s;
        next_s.now      = s.now + TIME_W'(`ETS_NS_STEP);
        next_s.req.sel  = addr_taken(hsel, htrans, hready);
        next_s.req.write = hwrite;
        next_s.req.addr = haddr[7:0];
        if (s.req.sel && s.req.write) begin
            unique case (s.req.addr)
                8'(`ETS_OFS_CTRL): next_s.ctrl = hwdata[1:0];
                8'(`ETS_OFS_STAT): next_s.stat = s.stat & ~hwdata[3:0];
                8'(`ETS_OFS_MASK): next_s.mask = hwdata[3:0];
                default:           next_s.ctrl = next_s.ctrl;
            endcase
        end
        next_s.stat  = next_s.stat | events;                                       // set wins
        next_s.rdata = (addr_taken(hsel, htrans, hready) && !hwrite)
                     ? read_word(haddr[7:0], s, chs[0], chs[1]) : s.rdata;
        next_s.irq   = |(next_s.stat & next_s.mask);
        next_s.ready = 1'b1;
        next_s.resp  = 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s      <= '0;
            s.ctrl <= `ETS_CTRL_RST;
            s.mask <= `ETS_MASK_RST;
            s.ready <= `ETS_READY_RST;
        end else begin
            s <= next_s;
        end
    end

    assign hrdata    = s.rdata;
    assign hreadyout = s.ready;
    assign hresp     = s.resp;
    assign irq       = s.irq;

    property p_time_runs;
        @(posedge hclk) disable iff (!hresetn)
        hresetn |=> s.now == $past(s.now) + TIME_W'(`ETS_NS_STEP);
    endproperty
    a_time_runs: assert property (p_time_runs)
        else $error("time base not free running");

    property p_event_sticky;
        @(posedge hclk) disable iff (!hresetn)
        rise_p[0] |=> s.stat[0];
    endproperty
    a_event_sticky: assert property (p_event_sticky) else $error("event not latched");

    // bus answers in zero wait states and always okay
    property p_bus_okay;
        @(posedge hclk) disable iff (!hresetn)
        hresetn |-> hreadyout && !hresp;
    endproperty
    a_bus_okay: assert property (p_bus_okay)
        else $error("bus answer not zero-wait okay");

    sequence s_rd_level;
        hresetn && addr_taken(hsel, htrans, hready) && !hwrite
            && (haddr[7:0] == 8'(`ETS_OFS_LEVEL));
    endsequence
    property p_read_level;
        @(posedge hclk) disable iff (!hresetn)
        s_rd_level |=> hrdata == {30'h0, $past(chs[1].level), $past(chs[0].level)};
    endproperty
    a_read_level: assert property (p_read_level)
        else $error("level word not read back");

    // read data stands until the next read address phase
    property p_rdata_hold;
        @(posedge hclk) disable iff (!hresetn)
        hresetn && !(addr_taken(hsel, htrans, hready) && !hwrite) |=> $stable(hrdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data changed without read");

    sequence s_ctrl_write;
        hresetn && wr_hit(s.req, 8'(`ETS_OFS_CTRL));
    endsequence
    property p_ctrl_write;
        @(posedge hclk) disable iff (!hresetn)
        s_ctrl_write |=> s.ctrl == $past(hwdata[1:0]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("capture enable not written");

    sequence s_stat_clear;
        hresetn && wr_hit(s.req, 8'(`ETS_OFS_STAT)) && (events == 4'h0);
    endsequence
    property p_stat_clear;
        @(posedge hclk) disable iff (!hresetn)
        s_stat_clear |=> (s.stat & $past(hwdata[3:0])) == 4'h0;
    endproperty
    a_stat_clear: assert property (p_stat_clear)
        else $error("status bit not cleared by a one");

    // an event in the clear cycle still leaves its bit set
    property p_stat_set_wins;
        @(posedge hclk) disable iff (!hresetn)
        hresetn && (events != 4'h0) |=> (s.stat & $past(events)) == $past(events);
    endproperty
    a_stat_set_wins: assert property (p_stat_set_wins)
        else $error("event lost");

    property p_stat_hold;
        @(posedge hclk) disable iff (!hresetn)
        hresetn && (events == 4'h0) && !wr_hit(s.req, 8'(`ETS_OFS_STAT)) |=> $stable(s.stat);
    endproperty
    a_stat_hold: assert property (p_stat_hold)
        else $error("status changed without event or clear");

    property p_irq_level;
        @(posedge hclk) disable iff (!hresetn)
        hresetn |-> irq == (|(s.stat & s.mask));
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt not following status and mask");

    // a disabled channel still mirrors its level but records nothing
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_off
            property p_off_no_stamp;
                @(posedge hclk) disable iff (!hresetn)
                hresetn && !s.ctrl[g] |=> !rise_p[g] && !fall_p[g];
            endproperty
            a_off_no_stamp: assert property (p_off_no_stamp)
                else $error("edge recorded on disabled channel");
        end
    endgenerate
endmodule : ets_top

// ---- bench/ets_ctl_model.sv ----
// cyclic controller model: AHB-Lite master that reads the process image
`timescale 1ns/100ps
`include "ets_cfg.svh"
module ets_ctl_model (
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    initial begin
        {hsel, haddr, htrans, hwrite, hwdata} = '0;
        hsize = 3'h2;
    end
    task xfer(input logic w, input logic [31:0] a, d, output logic [31:0] q);
        @(posedge hclk);
        {hsel, haddr, htrans, hwrite} <= {1'b1, a, 2'h2, w};
        do @(posedge hclk); while (hready !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
        // released data bus must not keep showing the last word
        hwdata <= ~d;
    endtask : xfer
    // one snapshot per controller cycle; edges in between are not seen
    task snap(input int ch, output logic [31:0] lvl, dir, output logic [63:0] r, f);
        xfer(1'b0, `ETS_OFS_LEVEL, 32'h0, lvl);
        xfer(1'b0, 32'(`ETS_OFS_DIR1 + 4 * ch), 32'h0, dir);
        xfer(1'b0, 32'(`ETS_OFS_RISE1_LO + 16 * ch), 32'h0, r[31:0]);
        xfer(1'b0, 32'(`ETS_OFS_RISE1_LO + 16 * ch + 4), 32'h0, r[63:32]);
        xfer(1'b0, 32'(`ETS_OFS_RISE1_LO + 16 * ch + 8), 32'h0, f[31:0]);
        xfer(1'b0, 32'(`ETS_OFS_RISE1_LO + 16 * ch + 12), 32'h0, f[63:32]);
    endtask : snap
endmodule : ets_ctl_model

// ---- bench/edge_timestamp_capture_test.sv ----
// self-checking bench of the timestamp unit
`timescale 1ns/100ps
`include "ets_cfg.svh"
module edge_timestamp_capture_test;
    typedef struct packed { logic [31:0] a; logic [31:0] e; } ets_row_t;
    logic        hclk, hresetn, hsel, hwrite, hready, hresp, irq;
    logic [1:0]  htrans, pin;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, q, lvl, dir;
    logic [63:0] r, f;
    int          error_cnt = 0;
    int          checked = 0;
    ets_row_t    rows [10] = '{'{`ETS_OFS_CTRL, 32'h3}, '{`ETS_OFS_LEVEL, 32'h0},
        '{`ETS_OFS_STAT, 32'h0}, '{`ETS_OFS_MASK, 32'h0}, '{`ETS_OFS_DIR1, 32'h0},
        '{`ETS_OFS_DIR2, 32'h0}, '{`ETS_OFS_RISE1_LO, 32'h0}, '{32'h5c, 32'h0},
        '{32'h24, 32'h0}, '{32'h80, 32'h0}};

    ets_top u_ets_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .first_input_socket(pin[0]),
        .second_input_socket(pin[1]), .irq(irq));
    ets_ctl_model u_ets_ctl_model (.hclk(hclk), .hready(hready), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata));

    task automatic chk(input string n, input logic [63:0] got, exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, exp, got);
        end
    endtask : chk

    task print_verdict;
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    initial begin
        repeat (3000) @(posedge hclk);
        error_cnt++;
        print_verdict();
    end

    initial begin
        hresetn = 1'b0;
        pin = 2'b00;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (rows[i]) begin
            u_ets_ctl_model.xfer(1'b0, rows[i].a, 32'h0, q);
            chk("reset value", q, {32'h0, rows[i].e});
        end
        chk("hresp okay", hresp, 64'h0);
        u_ets_ctl_model.xfer(1'b1, 32'h80, 32'hffffffff, q);
        u_ets_ctl_model.xfer(1'b0, 32'h80, 32'h0, q);
        chk("unmapped", q, 64'h0);
        u_ets_ctl_model.xfer(1'b1, `ETS_OFS_MASK, 32'hf, q);
        // ch1 and ch2 each rise twice per snapshot: only the last edges survive
        @(posedge hclk);
        pin <= 2'b11;
        repeat (4) @(posedge hclk);
        pin <= 2'b01;
        repeat (3) @(posedge hclk);
        pin <= 2'b00;
        repeat (3) @(posedge hclk);
        pin <= 2'b10;
        repeat (2) @(posedge hclk);
        pin <= 2'b11;
        repeat (9) @(posedge hclk);
        pin <= 2'b10;
        repeat (5) @(posedge hclk);
        u_ets_ctl_model.snap(0, lvl, dir, r, f);
        chk("level", lvl, 64'h2);
        chk("ch1 dir", dir, 64'h0);
        chk("ch1 fall minus rise", f - r, 64'd90);
        u_ets_ctl_model.snap(1, lvl, dir, r, f);
        chk("ch2 dir", dir, 64'h8);
        chk("ch2 rise minus fall", r - f, 64'd60);
        u_ets_ctl_model.xfer(1'b0, `ETS_OFS_STAT, 32'h0, q);
        chk("stat", q, 64'hf);
        chk("irq raised", irq, 64'h1);
        u_ets_ctl_model.xfer(1'b1, `ETS_OFS_MASK, 32'h0, q);
        repeat (2) @(posedge hclk);
        chk("irq masked", irq, 64'h0);
        u_ets_ctl_model.xfer(1'b1, `ETS_OFS_MASK, 32'hf, q);
        repeat (2) @(posedge hclk);
        chk("irq unmasked", irq, 64'h1);
        u_ets_ctl_model.xfer(1'b1, `ETS_OFS_STAT, 32'hf, q);
        repeat (2) @(posedge hclk);
        chk("irq cleared", irq, 64'h0);
        u_ets_ctl_model.xfer(1'b0, `ETS_OFS_STAT, 32'h0, q);
        chk("stat cleared", q, 64'h0);
        // ch1 disabled: level still follows, no event and no new direction
        u_ets_ctl_model.xfer(1'b1, `ETS_OFS_CTRL, 32'h2, q);
        pin <= 2'b11;
        repeat (5) @(posedge hclk);
        u_ets_ctl_model.xfer(1'b0, `ETS_OFS_LEVEL, 32'h0, q);
        chk("level while disabled", q, 64'h3);
        u_ets_ctl_model.xfer(1'b0, `ETS_OFS_STAT, 32'h0, q);
        chk("no event while disabled", q, 64'h0);
        u_ets_ctl_model.xfer(1'b0, `ETS_OFS_DIR1, 32'h0, q);
        chk("dir kept while disabled", q, 64'h0);
        u_ets_ctl_model.xfer(1'b1, `ETS_OFS_CTRL, 32'h3, q);
        pin <= 2'b10;
        repeat (5) @(posedge hclk);
        u_ets_ctl_model.xfer(1'b0, `ETS_OFS_STAT, 32'h0, q);
        chk("fall after enable", q, 64'h2);
        // mid-run reset with the inputs low brings the ten words of the table back to their reset values
        pin <= 2'b00;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b0;
        @(posedge hclk);
        hresetn <= 1'b1;
        foreach (rows[i]) begin
            u_ets_ctl_model.xfer(1'b0, rows[i].a, 32'h0, q);
            chk("value after second reset", q, {32'h0, rows[i].e});
        end
        chk("irq after reset", irq, 64'h0);
        print_verdict();
    end
endmodule : edge_timestamp_capture_test
